// ===== design/pll_ref_vco_ctrl.v
// pll reference selection, reference divider, charge pump and vco calibration
//
// The Wishbone register port and the address map were chosen for this implementation.
`timescale 1ns/100ps
`default_nettype none
`include "pll_ctrl_consts.vh"

module pll_ref_vco_ctrl
#(
  parameter CAL_CYCLES = `CAL_MAX_CYCLES
)
(
  input  wire        clock,
  input  wire        rst_n,
  input  wire        wb_cyc_i,
  input  wire        wb_stb_i,
  input  wire        wb_we_i,
  input  wire [13:0] wb_adr_i,
  input  wire [3:0]  wb_sel_i,
  input  wire [31:0] wb_dat_i,
  output reg  [31:0] wb_dat_o,
  output reg         wb_ack_o,
  input  wire        primary_reference,
  input  wire        secondary_reference,
  input  wire        differential_reference_input,
  input  wire        ref_select_pin,
  input  wire        align_n,
  output reg         prim_rx_enable,
  output reg         sec_rx_enable,
  output reg         diff_rx_enable,
  output reg         use_secondary,
  output reg         phase_detector_ref_pulse,
  output reg         feedback_counter_reset,
  output reg  [1:0]  pll_power_mode,
  output reg  [1:0]  charge_pump_mode,
  output reg  [2:0]  charge_pump_current,
  output reg         phase_detector_negative,
  output reg         outputs_hold,
  output reg         output_sync_pulse,
  output reg  [2:0]  vco_divider_ratio,
  output reg         dist_from_clk_input,
  output reg         dist_select_vco
);

  // shadow settings written over the bus
  reg  [7:0]  sh_pll_r;
  reg  [7:0]  sh_rlo_r;
  reg  [5:0]  sh_rhi_r;
  reg  [7:0]  sh_crst_r;
  reg  [7:0]  sh_cal_r;
  reg  [7:0]  sh_ref_r;
  reg  [2:0]  sh_vdiv_r;
  reg  [1:0]  sh_dist_r;
  // active settings
  reg  [7:0]  act_pll_r;
  reg  [13:0] act_rdiv_r;
  reg  [7:0]  act_crst_r;
  reg  [7:0]  act_cal_r;
  reg  [7:0]  act_ref_r;
  // pin synchronisers and edge detectors
  reg  [2:0]  pin_s1_r;
  reg  [2:0]  pin_s2_r;
  reg  [2:0]  pin_d_r;
  reg         sel_s1_r;
  reg         sel_s2_r;
  reg         aln_s1_r;
  reg         aln_s2_r;
  reg         aln_d_r;
  // reference divider and calibration
  reg  [13:0] rdiv_cnt_r;
  reg  [3:0]  cdiv_cnt_r;
  reg  [12:0] cal_cnt_r;
  reg         cal_busy_r;
  reg         cal_done_r;
  reg         cal_bit_d_r;
  reg         update_r;
  wire [11:0] idx;
  wire        wr_en;
  wire [7:0]  wd;
  wire [2:0]  pin_edge;
  wire        pll_on;
  wire        diff_mode;
  wire        use_sec;
  wire        prim_lost;
  wire        ref_edge;
  wire        rdiv_clear;
  wire        cal_tick;
  wire [3:0]  cal_div_last;
  wire [12:0] cal_last;
  wire [7:0]  rst_pll;
  wire [7:0]  rst_rhi;
  wire [7:0]  rst_vdiv;
  wire [7:0]  rst_dist;

  assign idx   = wb_adr_i[13:2];
  assign wr_en = wb_cyc_i && wb_stb_i && wb_we_i && wb_sel_i[0] && !wb_ack_o;
  assign wd    = wb_dat_i[7:0];

  // reset values, cut to the width of each field
  assign rst_pll  = `RST_PLL_CTRL;
  assign rst_rhi  = `RST_RDIV_HI;
  assign rst_vdiv = `RST_VCO_DIV;
  assign rst_dist = `RST_DIST_SRC;

  // bus handshake: one wait cycle, ack for one cycle
  always @(posedge clock)
  begin
    if (!rst_n)
      wb_ack_o <= 1'b0;
    else
      wb_ack_o <= wb_cyc_i && wb_stb_i && !wb_ack_o;
  end

  // shadow writes; unmapped indices are ignored
  always @(posedge clock)
  begin
    if (!rst_n)
    begin
      sh_pll_r  <= `RST_PLL_CTRL;
      sh_rlo_r  <= `RST_RDIV_LO;
      sh_rhi_r  <= rst_rhi[5:0];
      sh_crst_r <= `RST_CNT_RESET;
      sh_cal_r  <= `RST_VCO_CAL;
      sh_ref_r  <= `RST_REF_SEL;
      sh_vdiv_r <= rst_vdiv[2:0];
      sh_dist_r <= rst_dist[1:0];
      update_r  <= 1'b0;
    end
    else
    begin
      update_r <= wr_en && idx == `IDX_UPDATE && wd[`UPDATE_BIT];
      if (wr_en)
      begin
        if (idx == `IDX_PLL_CTRL)
          sh_pll_r <= wd;
        else if (idx == `IDX_RDIV_LO)
          sh_rlo_r <= wd;
        else if (idx == `IDX_RDIV_HI)
          sh_rhi_r <= wd[5:0];
        else if (idx == `IDX_CNT_RESET)
          sh_crst_r <= wd;
        else if (idx == `IDX_VCO_CAL)
          sh_cal_r <= wd;
        else if (idx == `IDX_REF_SEL)
          sh_ref_r <= wd;
        else if (idx == `IDX_VCO_DIV)
          sh_vdiv_r <= wd[2:0];
        else if (idx == `IDX_DIST_SRC)
          sh_dist_r <= wd[1:0];
      end
    end
  end

  // transfer of shadow to active settings
  always @(posedge clock)
  begin
    if (!rst_n)
    begin
      act_pll_r           <= `RST_PLL_CTRL;
      act_rdiv_r          <= {rst_rhi[5:0], `RST_RDIV_LO};
      act_crst_r          <= `RST_CNT_RESET;
      act_cal_r           <= `RST_VCO_CAL;
      act_ref_r           <= `RST_REF_SEL;
      vco_divider_ratio   <= 3'h0;
      dist_from_clk_input <= 1'b0;
      dist_select_vco     <= 1'b0;
    end
    else if (update_r)
    begin
      act_pll_r           <= sh_pll_r;
      act_rdiv_r          <= {sh_rhi_r, sh_rlo_r};
      act_crst_r          <= sh_crst_r;
      act_cal_r           <= sh_cal_r;
      act_ref_r           <= sh_ref_r;
      vco_divider_ratio   <= sh_vdiv_r;
      dist_from_clk_input <= sh_dist_r[`DIST_CLKIN_BIT];
      dist_select_vco     <= sh_dist_r[`DIST_VCO_BIT];
    end
  end

  // read data: shadow settings and live state
  always @(posedge clock)
  begin
    if (!rst_n)
      wb_dat_o <= 32'h00000000;
    else if (wb_cyc_i && wb_stb_i && !wb_ack_o)
    begin
      if (idx == `IDX_PLL_CTRL)
        wb_dat_o <= {24'h000000, sh_pll_r};
      else if (idx == `IDX_RDIV_LO)
        wb_dat_o <= {24'h000000, sh_rlo_r};
      else if (idx == `IDX_RDIV_HI)
        wb_dat_o <= {26'h0000000, sh_rhi_r};
      else if (idx == `IDX_CNT_RESET)
        wb_dat_o <= {24'h000000, sh_crst_r};
      else if (idx == `IDX_VCO_CAL)
        wb_dat_o <= {24'h000000, sh_cal_r};
      else if (idx == `IDX_REF_SEL)
        wb_dat_o <= {24'h000000, sh_ref_r};
      else if (idx == `IDX_READBACK)
        wb_dat_o <= {25'h0000000, cal_done_r, 3'h0, cal_busy_r,
                     prim_lost, use_sec};
      else if (idx == `IDX_VCO_DIV)
        wb_dat_o <= {29'h00000000, sh_vdiv_r};
      else if (idx == `IDX_DIST_SRC)
        wb_dat_o <= {30'h00000000, sh_dist_r};
      else
        wb_dat_o <= 32'h00000000;
    end
  end

  // two-stage synchronisers on all pins
  always @(posedge clock)
  begin
    if (!rst_n)
    begin
      pin_s1_r <= 3'h0;
      pin_s2_r <= 3'h0;
      pin_d_r  <= 3'h0;
      sel_s1_r <= 1'b0;
      sel_s2_r <= 1'b0;
      aln_s1_r <= 1'b1;
      aln_s2_r <= 1'b1;
      aln_d_r  <= 1'b1;
    end
    else
    begin
      pin_s1_r <= {differential_reference_input, secondary_reference,
                   primary_reference};
      pin_s2_r <= pin_s1_r;
      pin_d_r  <= pin_s2_r;
      sel_s1_r <= ref_select_pin;
      sel_s2_r <= sel_s1_r;
      aln_s1_r <= align_n;
      aln_s2_r <= aln_s1_r;
      aln_d_r  <= aln_s2_r;
    end
  end

  // rising edge per reference pin
  genvar g;
  generate
    for (g = 0; g < 3; g = g + 1)
    begin : edge_det
      assign pin_edge[g] = pin_s2_r[g] && !pin_d_r[g];
    end
  endgenerate

  assign pll_on    = act_pll_r[`PLL_PWR_LSB+1:`PLL_PWR_LSB]
                     == `PLL_PWR_NORMAL;
  assign diff_mode = act_ref_r[`REF_DIFF_BIT];

  ref_switchover u_switch
  (
    .clock       (clock),
    .rst_n       (rst_n),
    .prim_edge   (pin_edge[0] && prim_rx_enable),
    .sec_edge    (pin_edge[1] && sec_rx_enable),
    .auto_mode   (act_ref_r[`AUTO_SW_BIT]),
    .non_revert  (act_ref_r[`NONREVERT_BIT]),
    .manual_sec  (act_ref_r[`SEL_BY_PIN_BIT] ? sel_s2_r
                  : act_ref_r[`SEL_SEC_BIT]),
    .use_sec_r   (use_sec),
    .prim_lost_r (prim_lost)
  );

  // receiver power and selected reference
  always @(posedge clock)
  begin
    if (!rst_n)
    begin
      prim_rx_enable <= 1'b0;
      sec_rx_enable  <= 1'b0;
      diff_rx_enable <= 1'b0;
      use_secondary  <= 1'b0;
    end
    else
    begin
      prim_rx_enable <= pll_on && !diff_mode
                        && act_ref_r[`REF_PRIM_EN_BIT];
      sec_rx_enable  <= pll_on && !diff_mode
                        && act_ref_r[`REF_SEC_EN_BIT];
      diff_rx_enable <= pll_on && diff_mode;
      use_secondary  <= use_sec;
    end
  end

  assign ref_edge   = diff_mode ? (pin_edge[2] && diff_rx_enable)
                      : use_sec ? (pin_edge[1] && sec_rx_enable)
                      : (pin_edge[0] && prim_rx_enable);
  assign rdiv_clear = act_crst_r[`RDIV_RST_BIT]
                      || act_crst_r[`SHARED_RST_BIT]
                      || (aln_s2_r && !aln_d_r);

  // reference divider: pulse per divided reference period
  always @(posedge clock)
  begin
    if (!rst_n || rdiv_clear)
    begin
      rdiv_cnt_r               <= 14'h0000;
      phase_detector_ref_pulse <= 1'b0;
    end
    else if (ref_edge)
    begin
      if (rdiv_cnt_r + 14'h0001 >= act_rdiv_r)
      begin
        rdiv_cnt_r               <= 14'h0000;
        phase_detector_ref_pulse <= 1'b1;
      end
      else
      begin
        rdiv_cnt_r               <= rdiv_cnt_r + 14'h0001;
        phase_detector_ref_pulse <= 1'b0;
      end
    end
    else
      phase_detector_ref_pulse <= 1'b0;
  end

  // shared and a/b counter resets reach the feedback divider
  always @(posedge clock)
  begin
    if (!rst_n)
      feedback_counter_reset <= 1'b0;
    else
      feedback_counter_reset <= act_crst_r[`SHARED_RST_BIT]
                                || act_crst_r[`AB_RST_BIT];
  end

  // charge pump and phase detector settings
  always @(posedge clock)
  begin
    if (!rst_n)
    begin
      pll_power_mode          <= rst_pll[`PLL_PWR_LSB+1:`PLL_PWR_LSB];
      charge_pump_mode        <= 2'h0;
      charge_pump_current     <= 3'h0;
      phase_detector_negative <= 1'b0;
    end
    else
    begin
      pll_power_mode          <= act_pll_r[`PLL_PWR_LSB+1:`PLL_PWR_LSB];
      charge_pump_mode        <= act_pll_r[`CP_MODE_LSB+1:`CP_MODE_LSB];
      charge_pump_current     <= act_pll_r[`CP_CUR_LSB+2:`CP_CUR_LSB];
      phase_detector_negative <= act_pll_r[`PFD_POL_BIT];
    end
  end
  // mode encodes normal, high-z, up, down
  // current is (code + 1) x 0.6 mA

  // calibration clock: phase detector pulses divided by 2, 4, 8 or 16
  assign cal_div_last = (4'h2 << act_cal_r[`CAL_DIV_LSB+1:`CAL_DIV_LSB])
                        - 4'h1;
  assign cal_tick     = phase_detector_ref_pulse
                        && cdiv_cnt_r == cal_div_last;
  assign cal_last     = CAL_CYCLES[12:0] - 13'h0001;

  always @(posedge clock)
  begin
    if (!rst_n || !cal_busy_r)
      cdiv_cnt_r <= 4'h0;
    else if (phase_detector_ref_pulse)
      cdiv_cnt_r <= cal_tick ? 4'h0 : cdiv_cnt_r + 4'h1;
  end

  // calibration sequence started by a rising calibration bit
  always @(posedge clock)
  begin
    if (!rst_n)
    begin
      cal_bit_d_r       <= 1'b0;
      cal_busy_r        <= 1'b0;
      cal_done_r        <= 1'b0;
      cal_cnt_r         <= 13'h0000;
      output_sync_pulse <= 1'b0;
      outputs_hold      <= 1'b0;
    end
    else
    begin
      cal_bit_d_r       <= act_cal_r[`CAL_START_BIT];
      output_sync_pulse <= 1'b0;
      if (!act_cal_r[`CAL_START_BIT])
      begin
        cal_busy_r <= 1'b0;
        cal_done_r <= 1'b0;
      end
      else if (!cal_bit_d_r)
      begin
        cal_busy_r        <= 1'b1;
        cal_done_r        <= 1'b0;
        cal_cnt_r         <= 13'h0000;
        output_sync_pulse <= 1'b1;
      end
      else if (cal_busy_r && cal_tick)
      begin
        if (cal_cnt_r == cal_last)
        begin
          cal_busy_r <= 1'b0;
          cal_done_r <= 1'b1;
        end
        else
          cal_cnt_r <= cal_cnt_r + 13'h0001;
      end
      outputs_hold <= cal_busy_r;
    end
  end

endmodule // pll_ref_vco_ctrl

`default_nettype wire

// ===== design/pll_ctrl_consts.vh
// register offsets, field positions, reset values and counts of the pll control
`ifndef PLL_CTRL_CONSTS_VH
`define PLL_CTRL_CONSTS_VH

// register indices; byte address is four times the index
`define IDX_PLL_CTRL     12'h010
`define IDX_RDIV_LO      12'h011
`define IDX_RDIV_HI      12'h012
`define IDX_CNT_RESET    12'h016
`define IDX_VCO_CAL      12'h018
`define IDX_REF_SEL      12'h01C
`define IDX_READBACK     12'h01F
`define IDX_VCO_DIV      12'h1E0
`define IDX_DIST_SRC     12'h1E1
`define IDX_UPDATE       12'h232

// pll control fields
`define PLL_PWR_LSB      0
`define CP_MODE_LSB      2
`define CP_CUR_LSB       4
`define PFD_POL_BIT      7
`define PLL_PWR_NORMAL   2'h0

// counter reset fields
`define RDIV_RST_BIT     6
`define SHARED_RST_BIT   5
`define AB_RST_BIT       4

// calibration fields
`define CAL_START_BIT    0
`define CAL_DIV_LSB      1

// reference selection fields
`define REF_PRIM_EN_BIT  0
`define REF_SEC_EN_BIT   1
`define REF_DIFF_BIT     2
`define NONREVERT_BIT    3
`define AUTO_SW_BIT      4
`define SEL_BY_PIN_BIT   5
`define SEL_SEC_BIT      6

// readback fields
`define RB_ON_SEC_BIT    0
`define RB_PRIM_LOST_BIT 1
`define RB_CAL_BUSY_BIT  2
`define RB_CAL_DONE_BIT  6

// distribution source fields
`define DIST_CLKIN_BIT   0
`define DIST_VCO_BIT     1

// update field
`define UPDATE_BIT       0

// reset values
`define RST_PLL_CTRL     8'h01
`define RST_RDIV_LO      8'h01
`define RST_RDIV_HI      8'h00
`define RST_CNT_RESET    8'h00
`define RST_VCO_CAL      8'h00
`define RST_REF_SEL      8'h00
`define RST_VCO_DIV      8'h00
`define RST_DIST_SRC     8'h00

// switchover edge counts
`define LOST_SEC_EDGES   2'h3
`define BACK_PRIM_EDGES  3'h4
`define SWITCH_DELAY     2'h2

// longest calibration, in calibration clock cycles
`define CAL_MAX_CYCLES   4400

`endif

// ===== design/ref_switchover.v
// automatic and manual switchover between primary and secondary references
`timescale 1ns/100ps
`default_nettype none
`include "pll_ctrl_consts.vh"

module ref_switchover
(
  input  wire       clock,
  input  wire       rst_n,
  input  wire       prim_edge,
  input  wire       sec_edge,
  input  wire       auto_mode,
  input  wire       non_revert,
  input  wire       manual_sec,
  output reg        use_sec_r,
  output reg        prim_lost_r
);

  reg  [1:0] sec_run_r;
  reg  [2:0] prim_run_r;
  reg  [1:0] pend_cnt_r;
  reg        pend_r;
  wire       lost_now;
  wire       back_now;

  // three secondary edges with no primary edge in between
  assign lost_now = sec_edge && !prim_edge
                    && (sec_run_r == `LOST_SEC_EDGES - 2'h1);
  // four primary edges without three secondary edges between them
  assign back_now = prim_edge && prim_lost_r
                    && (prim_run_r == `BACK_PRIM_EDGES - 3'h1);

  always @(posedge clock)
  begin
    if (!rst_n || !auto_mode)
    begin
      sec_run_r   <= 2'h0;
      prim_run_r  <= 3'h0;
      pend_cnt_r  <= 2'h0;
      pend_r      <= 1'b0;
      prim_lost_r <= 1'b0;
      use_sec_r   <= !rst_n ? 1'b0 : manual_sec;
    end
    else
    begin
      if (prim_edge)
        sec_run_r <= 2'h0;
      else if (sec_edge && sec_run_r != `LOST_SEC_EDGES)
        sec_run_r <= sec_run_r + 2'h1;
      if (lost_now || (sec_edge && sec_run_r == `LOST_SEC_EDGES))
        prim_run_r <= 3'h0;
      else if (prim_edge && prim_run_r != `BACK_PRIM_EDGES)
        prim_run_r <= prim_run_r + 3'h1;
      if (lost_now && !prim_lost_r)
      begin
        prim_lost_r <= 1'b1;
        pend_r      <= !use_sec_r;
        pend_cnt_r  <= 2'h0;
      end
      else if (back_now)
      begin
        prim_lost_r <= 1'b0;
        pend_r      <= use_sec_r && !non_revert;
        pend_cnt_r  <= 2'h0;
      end
      else if (pend_r && sec_edge)
      begin
        if (pend_cnt_r == `SWITCH_DELAY - 2'h1)
        begin
          pend_r    <= 1'b0;
          use_sec_r <= prim_lost_r;
        end
        else
          pend_cnt_r <= pend_cnt_r + 2'h1;
      end
    end
  end

endmodule // ref_switchover

`default_nettype wire

// ===== tb/ref_source_model.sv
// reference oscillators feeding the pll control block
`timescale 1ns/100ps
`default_nettype none

module ref_source_model
(
  input  wire logic clock,
  input  wire logic prim_run,
  input  wire logic sec_run,
  output var  logic primary_reference,
  output var  logic secondary_reference,
  output var  logic differential_reference_input
);
  // primary period 4 clocks, secondary 6, so their phases keep moving
  // a stopped source holds its level, as a dead oscillator would
  logic [1:0] pc_r = 2'h0;
  logic [1:0] sc_r = 2'h0;

  initial
  begin
    primary_reference = 1'b0;
    secondary_reference = 1'b0;
    differential_reference_input = 1'b0;
  end

  always @(posedge clock)
  begin
    pc_r <= (pc_r == 2'h1) ? 2'h0 : pc_r + 2'h1;
    sc_r <= (sc_r == 2'h2) ? 2'h0 : sc_r + 2'h1;
    if (pc_r == 2'h1 && prim_run)
      primary_reference <= ~primary_reference;
    if (sc_r == 2'h2 && sec_run)
      secondary_reference <= ~secondary_reference;
    differential_reference_input <= primary_reference;
  end
endmodule // ref_source_model

`default_nettype wire

// ===== tb/pll_ref_vco_ctrl_chk.sv
// assertions on the pll control block ports
`timescale 1ns/100ps
`default_nettype none

module pll_ref_vco_ctrl_chk
#(
  parameter CAL_CYCLES = 4400
)
(
  input wire logic       clock,
  input wire logic       rst_n,
  input wire logic       wb_cyc_i,
  input wire logic       wb_stb_i,
  input wire logic       wb_ack_o,
  input wire logic       prim_rx_enable,
  input wire logic       sec_rx_enable,
  input wire logic       diff_rx_enable,
  input wire logic       use_secondary,
  input wire logic       phase_detector_ref_pulse,
  input wire logic [1:0] pll_power_mode,
  input wire logic       outputs_hold,
  input wire logic       output_sync_pulse
);
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!rst_n);

  a_ack_next: assert property (
    (wb_cyc_i && wb_stb_i && !wb_ack_o) |=> wb_ack_o)
    else $error("ack missing after request");
  a_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  a_ack_idle: assert property (!(wb_cyc_i && wb_stb_i) |=> !wb_ack_o)
    else $error("ack without request");
  a_diff_excl: assert property (
    diff_rx_enable |-> !(prim_rx_enable || sec_rx_enable))
    else $error("single-ended receiver on in differential mode");
  a_pwr_off: assert property (
    (pll_power_mode == 2'h1)[*2] |->
    !(prim_rx_enable || sec_rx_enable || diff_rx_enable))
    else $error("receiver on while pll powered down");
  a_pulse_short: assert property (
    phase_detector_ref_pulse |=> !phase_detector_ref_pulse)
    else $error("divider pulse too long");
  a_sync_once: assert property (
    output_sync_pulse |=> !output_sync_pulse)
    else $error("sync pulse too long");
  a_sync_hold: assert property (
    output_sync_pulse |-> ##[0:2] outputs_hold)
    else $error("outputs not held after sync");
  a_sel_steady: assert property (
    !$stable(use_secondary) |=> $stable(use_secondary)[*3])
    else $error("reference selection glitch");
endmodule // pll_ref_vco_ctrl_chk

`default_nettype wire

// ===== tb/tb_pll_ref_vco_ctrl.sv
// self-checking bench of the pll reference and vco control block
`timescale 1ns/100ps
`default_nettype none

module tb_pll_ref_vco_ctrl;
  localparam CAL_N = 4;
  logic        clock = 1'b0;
  logic        rst_n = 1'b0;
  logic        wb_cyc_i = 1'b0;
  logic        wb_stb_i = 1'b0;
  logic        wb_we_i = 1'b0;
  logic [3:0]  wb_sel_i = 4'hF;
  logic [13:0] wb_adr_i = 14'h0000;
  logic [31:0] wb_dat_i = 32'h0;
  logic        ref_select_pin = 1'b0;
  logic        align_n = 1'b1;
  logic        prim_run = 1'b1;
  logic        sec_run = 1'b1;
  wire  [31:0] wb_dat_o;
  wire  [1:0]  pll_power_mode, charge_pump_mode;
  wire  [2:0]  charge_pump_current, vco_divider_ratio;
  wire         wb_ack_o, prim_rx_enable, sec_rx_enable, diff_rx_enable;
  wire         use_secondary, phase_detector_ref_pulse, outputs_hold;
  wire         feedback_counter_reset, phase_detector_negative;
  wire         output_sync_pulse, dist_from_clk_input, dist_select_vco;
  wire         primary_reference, secondary_reference;
  wire         differential_reference_input;
  wire  [2:0]  rx = {prim_rx_enable, sec_rx_enable, diff_rx_enable};
  wire  [7:0]  pf = {phase_detector_negative, charge_pump_current,
                     charge_pump_mode, pll_power_mode};
  int          fails = 0;
  int          checks = 0;
  int          cyc_n = 0;
  int          hold_p = 0;
  int          syncs = 0;
  logic [31:0] rd_q[$];

  pll_ref_vco_ctrl #(.CAL_CYCLES(CAL_N)) pll_ref_vco_ctrl_i (
    .clock, .rst_n, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i,
    .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .primary_reference,
    .secondary_reference, .differential_reference_input, .ref_select_pin,
    .align_n, .prim_rx_enable, .sec_rx_enable, .diff_rx_enable,
    .use_secondary, .phase_detector_ref_pulse, .feedback_counter_reset,
    .pll_power_mode, .charge_pump_mode, .charge_pump_current,
    .phase_detector_negative, .outputs_hold, .output_sync_pulse,
    .vco_divider_ratio, .dist_from_clk_input, .dist_select_vco);

  ref_source_model ref_source_model_i (.clock, .prim_run, .sec_run,
    .primary_reference, .secondary_reference,
    .differential_reference_input);

  always #12.5 clock = ~clock;

  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction

  task automatic wrap_up();
    if (fails == 0 && checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp)
    begin
      fails++;
      $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // classic single cycle, held until ack, one idle edge after
  task automatic xfer(input logic we, input logic [11:0] a,
                      input logic [31:0] d);
    int n;
    n = 0;
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= {a, 2'b00};
    wb_dat_i <= d;
    do
    begin
      @(posedge clock);
      n++;
    end
    while (wb_ack_o !== 1'b1 && n < 40);
    if (n == 40)
      fails++;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    @(posedge clock);
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    xfer(1'b1, a, d);
  endtask

  task automatic rd(input logic [11:0] a, input logic [31:0] e);
    rd_q.push_back(e);
    xfer(1'b0, a, 32'h0);
  endtask

  task automatic upd();
    wr(12'h232, 32'h1);
    repeat (3) @(posedge clock);
  endtask

  task automatic to_pulse(output int g);
    g = 0;
    do
    begin
      @(posedge clock);
      g++;
    end
    while (phase_detector_ref_pulse !== 1'b1 && g < 3000);
  endtask

  task automatic wait_sec(input logic v, input int lim);
    int n;
    n = 0;
    while (use_secondary !== v && n < lim)
    begin
      @(posedge clock);
      n++;
    end
    chk(use_secondary, v);
  endtask

  always @(posedge clock)
  begin
    hold_p <= hold_p + (outputs_hold & phase_detector_ref_pulse);
    syncs <= syncs + output_sync_pulse;
    if (wb_ack_o === 1'b1 && wb_we_i === 1'b0 && rd_q.size() > 0)
      chk(wb_dat_o, rd_q.pop_front());
  end

  always @(posedge clock)
  begin
    cyc_n++;
    if (cyc_n == 20000)
    begin
      fails++;
      wrap_up();
    end
  end

  initial
  begin
    int g, c, h0, s0;
    logic [15:0] lf;
    logic [13:0] rv;
    logic [7:0] v;
    repeat (12) @(posedge clock);
    rst_n <= 1'b1;
    @(posedge clock);
    rd(12'h010, 32'h01);
    rd(12'h011, 32'h01);
    rd(12'h0FF, 32'h0);
    chk({pll_power_mode, rx}, 5'h08);
    lf = 16'h0425;
    c = 0;
    for (int i = 0; i < 8; i++)
    begin
      lf = lfsr(lf);
      v = {lf[0], i[2:0], i[1:0], 2'h0};
      wr(12'h010, v);
      repeat (3) @(posedge clock);
      chk(charge_pump_current, c);
      upd();
      chk(pf, v);
      rd(12'h010, v);
      c = i;
    end
    wr(12'h012, 32'hFF);
    rd(12'h012, 32'h3F);
    wb_sel_i <= 4'hE;
    wr(12'h011, 32'hAA);
    wb_sel_i <= 4'hF;
    rd(12'h011, 32'h01);
    wr(12'h01C, 32'h03);
    upd();
    chk(rx, 3'h6);
    wr(12'h01C, 32'h07);
    upd();
    chk(rx, 3'h1);
    wr(12'h01C, 32'h01);
    for (int k = 0; k < 5; k++)
    begin
      lf = lfsr(lf);
      rv = (k == 4) ? 14'h0005 : (k == 2) ? 14'h0103 : k[13:0];
      rv = (k == 3) ? {11'h000, lf[2:0]} + 14'h0002 : rv;
      wr(12'h011, rv[7:0]);
      wr(12'h012, rv[13:8]);
      upd();
      to_pulse(g);
      to_pulse(g);
      chk(g, 4 * ((rv == 0) ? 1 : rv));
    end
    to_pulse(g);
    repeat (12) @(posedge clock);
    align_n <= 1'b0;
    repeat (3) @(posedge clock);
    align_n <= 1'b1;
    to_pulse(c);
    chk(c > 12, 1'b1);
    for (int b = 0; b < 3; b++)
    begin
      wr(12'h016, (b == 0) ? 32'h40 : (b == 1) ? 32'h20 : 32'h10);
      upd();
      c = 0;
      repeat (60) @(posedge clock) c += phase_detector_ref_pulse;
      chk({feedback_counter_reset, c == 0}, {b != 0, b != 2});
    end
    wr(12'h016, 32'h0);
    wr(12'h01C, 32'h43);
    upd();
    chk(use_secondary, 1'b1);
    wr(12'h01C, 32'h23);
    ref_select_pin <= 1'b1;
    upd();
    wait_sec(1'b1, 8);
    ref_select_pin <= 1'b0;
    wait_sec(1'b0, 8);
    for (int m = 0; m < 2; m++)
    begin
      wr(12'h01C, (m == 0) ? 32'h13 : 32'h1B);
      upd();
      chk(use_secondary, 1'b0);
      prim_run <= 1'b0;
      repeat (12) @(posedge clock);
      chk(use_secondary, 1'b0);
      wait_sec(1'b1, 60);
      rd(12'h01F, 32'h03);
      prim_run <= 1'b1;
      if (m == 0)
        wait_sec(1'b0, 80);
    end
    repeat (100) @(posedge clock);
    chk(use_secondary, 1'b1);
    wr(12'h01C, 32'h01);
    wr(12'h011, 32'h0);
    upd();
    wait_sec(1'b0, 8);
    for (int d = 0; d < 4; d++)
    begin
      wr(12'h018, d * 2);
      upd();
      h0 = hold_p;
      s0 = syncs;
      wr(12'h018, d * 2 + 1);
      upd();
      for (c = 0; outputs_hold !== 1'b0 && c < 1000; c++)
        @(posedge clock);
      repeat (2) @(posedge clock);
      g = hold_p - h0 - CAL_N * (2 << d);
      chk(g >= -1 && g <= 1, 1'b1);
      chk(syncs - s0, 1);
      rd(12'h01F, 32'h40);
    end
    wr(12'h018, 32'h0);
    upd();
    rd(12'h01F, 32'h0);
    wr(12'h1E0, 32'h5);
    wr(12'h1E1, 32'h2);
    wr(12'h010, 32'h01);
    upd();
    chk({vco_divider_ratio, dist_from_clk_input, dist_select_vco}, 5'h15);
    chk(rx, 3'h0);
    wrap_up();
  end
endmodule // tb_pll_ref_vco_ctrl

bind pll_ref_vco_ctrl pll_ref_vco_ctrl_chk #(.CAL_CYCLES(CAL_CYCLES)) chk_i (
  .clock(clock), .rst_n(rst_n), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
  .wb_ack_o(wb_ack_o), .prim_rx_enable(prim_rx_enable),
  .sec_rx_enable(sec_rx_enable), .diff_rx_enable(diff_rx_enable),
  .use_secondary(use_secondary),
  .phase_detector_ref_pulse(phase_detector_ref_pulse),
  .pll_power_mode(pll_power_mode), .outputs_hold(outputs_hold),
  .output_sync_pulse(output_sync_pulse));

`default_nettype wire
